// ---- cond_eval.sv ----
// condition code evaluation from the z n c v flags
module cond_eval
    import jl_ld_pkg::*;
(
    exec_if.cond ifc
);
    logic z, n, c, v;
    assign z = ifc.flags[3];
    assign n = ifc.flags[2];
    assign c = ifc.flags[1];
    assign v = ifc.flags[0];

    always_comb
    begin
        unique case (ifc.cond_code)
            CC_AL: ifc.cond_true = 1'b1;
            CC_EQ: ifc.cond_true = z;
            CC_NE: ifc.cond_true = !z;
            CC_PL: ifc.cond_true = !n;
            CC_MI: ifc.cond_true = n;
            CC_CS: ifc.cond_true = c;
            CC_CC: ifc.cond_true = !c;
            CC_VS: ifc.cond_true = v;
            CC_VC: ifc.cond_true = !v;
            CC_GT: ifc.cond_true = (n && v && !z) || (!n && !v && !z);
            CC_GE: ifc.cond_true = (n && v) || (!n && !v);
            CC_LT: ifc.cond_true = (n && !v) || (!n && v);
            CC_LE: ifc.cond_true = z || (n && !v) || (!n && v);
            CC_HI: ifc.cond_true = !c && !z;
            CC_LS: ifc.cond_true = c || z;
            CC_PNZ: ifc.cond_true = !n && !z;
            default: ifc.cond_true = 1'b0;
        endcase
    end
endmodule

// ---- exec_if.sv ----
// condition and load-extension signals between the core and its helpers
interface exec_if;
    logic [4:0] cond_code;
    logic [3:0] flags;
    logic cond_true;
    logic [1:0] ld_size;
    logic ld_ext;
    logic [31:0] ld_raw;
    logic [31:0] ld_result;
    modport core (output cond_code, flags, ld_size, ld_ext, ld_raw,
                  input cond_true, ld_result);
    modport cond (input cond_code, flags, output cond_true);
    modport ext (input ld_size, ld_ext, ld_raw, output ld_result);
endinterface

// ---- jl_ld_exec.sv ----
// jump-with-link and load execute stage
module jl_ld_exec
    import jl_ld_pkg::*;
#(
    parameter int IMM_W = 11
)
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic ISSUE_VALID,
    input wire op_t ISSUE_OP,
    input wire logic [4:0] COND,
    input wire logic DELAY,
    input wire logic [1:0] SIZE,
    input wire logic SIGN_EXT,
    input wire logic BYPASS,
    input wire logic [1:0] WB_MODE,
    input wire logic [4:0] DEST_IDX,
    input wire logic [4:0] BASE_IDX,
    input wire logic [31:0] SRC1,
    input wire logic [31:0] SRC2,
    input wire logic [IMM_W-1:0] IMM,
    input wire logic [31:0] SP_VAL,
    input wire logic [31:0] GP_VAL,
    input wire logic [31:0] CUR_PC,
    input wire logic [31:0] NEXT_PC,
    input wire logic [3:0] FLAGS_ZNCV,
    input wire logic SLOT_FLOW,
    input wire logic SLOT_LOOP,
    input wire logic SLOT_IRET,
    input wire logic SLOT_LIMM,
    input wire logic MEM_RVALID,
    input wire logic [31:0] MEM_RDATA,
    output logic BUSY,
    output logic PC_LOAD,
    output logic [31:0] PC_VALUE,
    output logic SLOT_KILL,
    output logic WB_WE,
    output logic [4:0] WB_IDX,
    output logic [31:0] WB_DATA,
    output logic MEM_REQ,
    output logic [31:0] MEM_ADDR,
    output logic [1:0] MEM_SIZE,
    output logic MEM_BYPASS,
    output logic LD_WE,
    output logic [4:0] LD_IDX,
    output logic [31:0] LD_DATA,
    output logic EXC_SEQ,
    output logic EXC_INSTR,
    output logic FLAG_WE
);
    if (IMM_W < 9 || IMM_W > 16)
    begin : g_chk
        $error("IMM_W out of range");
    end

    typedef struct packed {
        logic busy;
        logic slot_open;
        logic pc_load;
        logic [31:0] pc_val;
        logic kill;
        logic wb_we;
        logic [4:0] wb_idx;
        logic [31:0] wb_data;
        logic mem_req;
        logic [31:0] mem_addr;
        logic [1:0] mem_size;
        logic mem_bypass;
        logic ld_ext;
        logic ld_we;
        logic [4:0] ld_idx;
        logic [31:0] ld_data;
        logic exc_seq;
        logic exc_instr;
        logic flag_we;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    exec_if ifc ();

    cond_eval u_cond (
        .ifc(ifc.cond)
    );

    load_extend u_ext (
        .ifc(ifc.ext)
    );

    // offset shift for a data size
    function automatic logic [1:0] size_shift(input logic [1:0] sz);
        logic [1:0] r;
        r = 2'h0;
        if (sz == SZ_LONG)
            r = 2'h2;
        else if (sz == SZ_WORD)
            r = 2'h1;
        return r;
    endfunction

    function automatic logic [31:0] uimm(input logic [IMM_W-1:0] v);
        return {{(32-IMM_W){1'b0}}, v};
    endfunction

    function automatic logic [31:0] simm(input logic [IMM_W-1:0] v);
        return {{(32-IMM_W){v[IMM_W-1]}}, v};
    endfunction

    always_comb
    begin
        ifc.cond_code = COND;
        ifc.flags = FLAGS_ZNCV;
        ifc.ld_size = st_ff.mem_size;
        ifc.ld_ext = st_ff.ld_ext;
        ifc.ld_raw = MEM_RDATA;
    end

    always_comb
    begin
        logic [1:0] sz;
        logic ext;
        logic byp;
        logic [1:0] mode;
        logic [31:0] base;
        logic [31:0] off;
        logic [31:0] sum;
        logic [4:0] dest;
        logic bad;
        sz = SIZE;
        ext = SIGN_EXT;
        byp = BYPASS;
        mode = WB_MODE;
        base = SRC1;
        off = SRC2;
        sum = 32'h0000_0000;
        dest = DEST_IDX;
        bad = 1'b0;
        nxt_st = st_ff;
        nxt_st.pc_load = 1'b0;
        nxt_st.kill = 1'b0;
        nxt_st.wb_we = 1'b0;
        nxt_st.mem_req = 1'b0;
        nxt_st.ld_we = 1'b0;
        nxt_st.exc_seq = 1'b0;
        nxt_st.exc_instr = 1'b0;
        nxt_st.flag_we = 1'b0;

        if (st_ff.busy && MEM_RVALID)
        begin
            nxt_st.busy = 1'b0;
            nxt_st.ld_we = 1'b1;
            nxt_st.ld_data = ifc.ld_result;
        end

        if (ISSUE_VALID && !st_ff.busy)
        begin
            nxt_st.slot_open = 1'b0;
            if (st_ff.slot_open && (SLOT_FLOW || SLOT_LOOP || SLOT_IRET || SLOT_LIMM))
            begin
                nxt_st.exc_seq = 1'b1;
            end
            else if (ISSUE_OP == OP_JL)
            begin
                nxt_st.pc_load = 1'b1;
                if (ifc.cond_true)
                begin
                    nxt_st.pc_val = {SRC1[31:1], 1'b0};
                    nxt_st.wb_we = 1'b1;
                    nxt_st.wb_idx = LINK_REG;
                    nxt_st.wb_data = DELAY ? NEXT_PC + SLOT_STEP : NEXT_PC;
                    nxt_st.kill = !DELAY;
                    nxt_st.slot_open = DELAY;
                end
                else
                begin
                    nxt_st.pc_val = NEXT_PC;
                end
            end
            else
            begin
                unique case (ISSUE_OP)
                    OP_LDS_RR:
                    begin
                        ext = 1'b0;
                        byp = 1'b0;
                        mode = WB_NONE;
                    end
                    OP_LDS_RI:
                    begin
                        ext = 1'b0;
                        byp = 1'b0;
                        mode = WB_NONE;
                        off = uimm(IMM) << size_shift(SIZE);
                    end
                    OP_LDWX:
                    begin
                        sz = SZ_WORD;
                        ext = 1'b1;
                        byp = 1'b0;
                        mode = WB_NONE;
                        off = uimm(IMM) << size_shift(SZ_WORD);
                    end
                    OP_LDS_SP:
                    begin
                        ext = 1'b0;
                        byp = 1'b0;
                        mode = WB_NONE;
                        base = SP_VAL;
                        off = uimm(IMM) << size_shift(SIZE);
                    end
                    OP_LDS_GP:
                    begin
                        ext = 1'b0;
                        byp = 1'b0;
                        mode = WB_NONE;
                        base = GP_VAL;
                        off = simm(IMM) << size_shift(SIZE);
                        dest = R0_REG;
                    end
                    OP_LDS_PCL:
                    begin
                        sz = SZ_LONG;
                        ext = 1'b0;
                        byp = 1'b0;
                        mode = WB_NONE;
                        base = {CUR_PC[31:2], 2'h0};
                        off = uimm(IMM) << size_shift(SZ_LONG);
                    end
                    default:
                    begin
                        sz = SIZE;
                    end
                endcase

                bad = (sz == SZ_RSVD)
                    || (sz == SZ_LONG && ext)
                    || (mode == WB_SCALED && sz == SZ_BYTE);
                sum = base + off;

                if (bad)
                begin
                    nxt_st.exc_instr = 1'b1;
                end
                else
                begin
                    nxt_st.mem_req = 1'b1;
                    nxt_st.mem_size = sz;
                    nxt_st.mem_bypass = byp;
                    nxt_st.ld_ext = ext;
                    nxt_st.ld_idx = dest;
                    nxt_st.busy = 1'b1;
                    unique case (mode)
                        WB_NONE: nxt_st.mem_addr = sum;
                        WB_PRE:
                        begin
                            nxt_st.mem_addr = sum;
                            nxt_st.wb_we = 1'b1;
                            nxt_st.wb_idx = BASE_IDX;
                            nxt_st.wb_data = sum;
                        end
                        WB_POST:
                        begin
                            nxt_st.mem_addr = base;
                            nxt_st.wb_we = 1'b1;
                            nxt_st.wb_idx = BASE_IDX;
                            nxt_st.wb_data = sum;
                        end
                        WB_SCALED: nxt_st.mem_addr = base + (off << size_shift(sz));
                    endcase
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            st_ff <= '0;
        else if (CE)
            st_ff <= nxt_st;
    end

    assign BUSY = st_ff.busy;
    assign PC_LOAD = st_ff.pc_load;
    assign PC_VALUE = st_ff.pc_val;
    assign SLOT_KILL = st_ff.kill;
    assign WB_WE = st_ff.wb_we;
    assign WB_IDX = st_ff.wb_idx;
    assign WB_DATA = st_ff.wb_data;
    assign MEM_REQ = st_ff.mem_req;
    assign MEM_ADDR = st_ff.mem_addr;
    assign MEM_SIZE = st_ff.mem_size;
    assign MEM_BYPASS = st_ff.mem_bypass;
    assign LD_WE = st_ff.ld_we;
    assign LD_IDX = st_ff.ld_idx;
    assign LD_DATA = st_ff.ld_data;
    assign EXC_SEQ = st_ff.exc_seq;
    assign EXC_INSTR = st_ff.exc_instr;
    assign FLAG_WE = st_ff.flag_we;
endmodule

// ---- jl_ld_exec_checker.sv ----
// port-level checks for the jump-with-link and load unit
module jl_ld_exec_checker
    import jl_ld_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic ISSUE_VALID,
    input wire op_t ISSUE_OP,
    input wire logic MEM_RVALID,
    input wire logic BUSY,
    input wire logic PC_LOAD,
    input wire logic [31:0] PC_VALUE,
    input wire logic SLOT_KILL,
    input wire logic WB_WE,
    input wire logic [4:0] WB_IDX,
    input wire logic MEM_REQ,
    input wire logic [1:0] MEM_SIZE,
    input wire logic LD_WE,
    input wire logic EXC_SEQ,
    input wire logic EXC_INSTR,
    input wire logic FLAG_WE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);
    sequence jl_take;
        CE && ISSUE_VALID && !BUSY && ISSUE_OP == OP_JL;
    endsequence
    sequence ld_back;
        CE && BUSY && MEM_RVALID;
    endsequence
    a_jl_answer: assert property (jl_take |=> (PC_LOAD || EXC_SEQ) && !MEM_REQ)
        else $error("jump gave no answer");
    a_link_index: assert property (PC_LOAD && WB_WE |-> WB_IDX == LINK_REG)
        else $error("link index wrong");
    a_kill_taken: assert property (SLOT_KILL |-> PC_LOAD && WB_WE)
        else $error("kill without taken jump");
    a_target_even: assert property (PC_LOAD |-> !PC_VALUE[0])
        else $error("odd jump target");
    a_flags_kept: assert property (!FLAG_WE)
        else $error("flags written");
    a_req_busy: assert property (MEM_REQ |-> BUSY && !PC_LOAD)
        else $error("request without busy");
    a_busy_wait: assert property (CE && BUSY && !MEM_RVALID |=> BUSY)
        else $error("busy dropped early");
    a_load_return: assert property (ld_back |=> LD_WE && !BUSY ##1 !LD_WE)
        else $error("load data not written once");
    a_size_legal: assert property (MEM_REQ |-> MEM_SIZE != SZ_RSVD)
        else $error("reserved size requested");
    a_illegal_noreq: assert property (EXC_INSTR |-> !MEM_REQ && !BUSY)
        else $error("illegal load issued");
endmodule

// ---- jl_ld_pkg.sv ----
// shared constants and types for the jump-with-link and load unit
package jl_ld_pkg;
    localparam int ADDR_W = 32;
    localparam logic [4:0] LINK_REG = 5'h1f;
    localparam logic [4:0] SP_REG = 5'h1c;
    localparam logic [4:0] GP_REG = 5'h1a;
    localparam logic [4:0] R0_REG = 5'h00;
    localparam logic [31:0] SLOT_STEP = 32'h0000_0004;
    localparam logic [1:0] SZ_LONG = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_RSVD = 2'h3;
    localparam logic [1:0] WB_NONE = 2'h0;
    localparam logic [1:0] WB_PRE = 2'h1;
    localparam logic [1:0] WB_POST = 2'h2;
    localparam logic [1:0] WB_SCALED = 2'h3;
    localparam logic [4:0] CC_AL = 5'h00;
    localparam logic [4:0] CC_EQ = 5'h01;
    localparam logic [4:0] CC_NE = 5'h02;
    localparam logic [4:0] CC_PL = 5'h03;
    localparam logic [4:0] CC_MI = 5'h04;
    localparam logic [4:0] CC_CS = 5'h05;
    localparam logic [4:0] CC_CC = 5'h06;
    localparam logic [4:0] CC_VS = 5'h07;
    localparam logic [4:0] CC_VC = 5'h08;
    localparam logic [4:0] CC_GT = 5'h09;
    localparam logic [4:0] CC_GE = 5'h0a;
    localparam logic [4:0] CC_LT = 5'h0b;
    localparam logic [4:0] CC_LE = 5'h0c;
    localparam logic [4:0] CC_HI = 5'h0d;
    localparam logic [4:0] CC_LS = 5'h0e;
    localparam logic [4:0] CC_PNZ = 5'h0f;

    typedef enum logic [2:0] {
        OP_JL,
        OP_LD,
        OP_LDS_RR,
        OP_LDS_RI,
        OP_LDWX,
        OP_LDS_SP,
        OP_LDS_GP,
        OP_LDS_PCL
    } op_t;
endpackage

// ---- load_extend.sv ----
// zero or sign extension of returned load data
module load_extend
    import jl_ld_pkg::*;
(
    exec_if.ext ifc
);
    always_comb
    begin
        unique case (ifc.ld_size)
            SZ_BYTE: ifc.ld_result = ifc.ld_ext ? {{24{ifc.ld_raw[7]}}, ifc.ld_raw[7:0]}
                                                : {24'h00_0000, ifc.ld_raw[7:0]};
            SZ_WORD: ifc.ld_result = ifc.ld_ext ? {{16{ifc.ld_raw[15]}}, ifc.ld_raw[15:0]}
                                                : {16'h0000, ifc.ld_raw[15:0]};
            default: ifc.ld_result = ifc.ld_raw;
        endcase
    end
endmodule

// ---- mem_port_model.sv ----
// far-side data memory answering one load after a set latency
module mem_port_model
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req,
    input wire logic [31:0] addr,
    input wire logic [3:0] lat,
    output logic rvalid,
    output logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt;
    logic [31:0] a;
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            cnt <= '0;
            rvalid <= 1'h0;
            rdata <= '0;
        end
        else
        begin
            rvalid <= cnt == 5'h1;
            rdata <= cnt == 5'h1 ? a ^ 32'h5a5a_a5a5 : ~rdata;
            if (req)
            begin
                cnt <= {1'h0, lat} + 5'h1;
                a <= addr;
            end
            else if (cnt != '0)
                cnt <= cnt - 5'h1;
        end
endmodule

// ---- tb_jl_ld_exec.sv ----
// self-checking bench for the jump-with-link and load unit
module tb_jl_ld_exec;
    timeunit 1ns;
    timeprecision 1ps;
    import jl_ld_pkg::*;
    logic clk = 1'h0, rst_b = 1'h0, vld = 1'h0, dly = 1'h0, sx = 1'h0, byp = 1'h0, rv;
    op_t op = OP_JL;
    logic [4:0] cond = '0, dst = 5'h03, bidx = 5'h02, wbi, ldi;
    logic [1:0] sz = '0, wbm = '0, msz;
    logic [31:0] s1 = 32'h0001_0100, s2 = 32'h0000_0024, rd, pcv, wbd, maddr, ldd;
    logic [31:0] sp = 32'h0000_2000, gp = 32'h0000_8000, pc = 32'h0000_0402;
    logic [31:0] next_instr_addr = 32'h0000_0406;
    logic [10:0] imm = 11'h7f9;
    logic [3:0] fl = '0, slot = '0, lat = '0;
    logic ce = 1'h1;
    logic busy, pcl, kill, wbwe, mreq, mbyp, ldwe, exs, exi, fwe;
    int num_errors = 0, samples_checked = 0;
    initial forever #5 clk = ~clk;
    jl_ld_exec dut (.CLK_SYS(clk), .RST_B(rst_b), .CE(ce), .ISSUE_VALID(vld), .ISSUE_OP(op),
        .COND(cond), .DELAY(dly), .SIZE(sz), .SIGN_EXT(sx), .BYPASS(byp), .WB_MODE(wbm),
        .DEST_IDX(dst), .BASE_IDX(bidx), .SRC1(s1), .SRC2(s2), .IMM(imm), .SP_VAL(sp),
        .GP_VAL(gp), .CUR_PC(pc), .NEXT_PC(next_instr_addr), .FLAGS_ZNCV(fl), .SLOT_FLOW(slot[0]),
        .SLOT_LOOP(slot[1]), .SLOT_IRET(slot[2]), .SLOT_LIMM(slot[3]), .MEM_RVALID(rv),
        .MEM_RDATA(rd), .BUSY(busy), .PC_LOAD(pcl), .PC_VALUE(pcv), .SLOT_KILL(kill),
        .WB_WE(wbwe), .WB_IDX(wbi), .WB_DATA(wbd), .MEM_REQ(mreq), .MEM_ADDR(maddr),
        .MEM_SIZE(msz), .MEM_BYPASS(mbyp), .LD_WE(ldwe), .LD_IDX(ldi), .LD_DATA(ldd),
        .EXC_SEQ(exs), .EXC_INSTR(exi), .FLAG_WE(fwe));
    mem_port_model mem (.clk(clk), .rst_b(rst_b), .req(mreq), .addr(maddr), .lat(lat),
        .rvalid(rv), .rdata(rd));
    task stop_test;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task issue;
        vld <= 1'h1;
        @(posedge clk);
        vld <= 1'h0;
        #1;
    endtask
    function logic ccv(input logic [4:0] c, input logic [3:0] f);
        logic z, n, k, v;
        {z, n, k, v} = f;
        case (c)
            5'h00: return 1'h1;
            5'h01: return z;
            5'h02: return !z;
            5'h03: return !n;
            5'h04: return n;
            5'h05: return k;
            5'h06: return !k;
            5'h07: return v;
            5'h08: return !v;
            5'h09: return !z && n == v;
            5'h0a: return n == v;
            5'h0b: return n != v;
            5'h0c: return z || n != v;
            5'h0d: return !k && !z;
            5'h0e: return k || z;
            5'h0f: return !n && !z;
            default: return 1'h0;
        endcase
    endfunction
    task t_cond;
        logic t;
        for (int c = 0; c < 17; c++)
            for (int f = 0; f < 16; f++)
            begin
                @(posedge clk);
                cond <= 5'(c);
                fl <= 4'(f);
                s1 <= 32'h1234_5677;
                issue();
                t = ccv(5'(c), 4'(f));
                chk(pcv, t ? 32'h1234_5676 : next_instr_addr);
                chk(wbwe, t);
                chk(kill, t);
                chk(fwe, 1'h0);
                if (t) chk(wbd, next_instr_addr);
            end
        s1 <= 32'h0001_0100;
    endtask
    task t_reset;
        @(posedge clk);
        rst_b <= 1'h0;
        @(posedge clk);
        #1;
        chk(pcv, 32'h0000_0000);
        chk(wbd, 32'h0000_0000);
        chk(busy, 1'h0);
        @(posedge clk);
        rst_b <= 1'h1;
    endtask
    task t_hold;
        @(posedge clk);
        ce <= 1'h0;
        cond <= 5'h00;
        s1 <= 32'h0000_0a0c;
        issue();
        chk(pcl, 1'h0);
        chk(pcv, next_instr_addr);
        @(posedge clk);
        ce <= 1'h1;
        issue();
        chk(pcl, 1'h1);
        chk(pcv, 32'h0000_0a0c);
    endtask
    task t_slot;
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk);
            cond <= 5'h00;
            dly <= 1'h1;
            issue();
            chk(wbd, next_instr_addr + SLOT_STEP);
            chk(kill, 1'h0);
            @(posedge clk);
            dly <= 1'h0;
            cond <= 5'h1f;
            slot <= 4'(1 << k);
            issue();
            chk(exs, k < 4);
            chk(pcl, k == 4);
        end
    endtask
    task ld_wait(input logic [31:0] a, input logic [1:0] z, input logic x, input logic [4:0] d);
        logic [31:0] w;
        w = a ^ 32'h5a5a_a5a5;
        chk(maddr, a);
        chk(msz, z);
        chk(busy, 1'h1);
        for (int i = 0; i < 20 && ldwe !== 1'h1; i++) @(posedge clk) #1;
        if (ldwe !== 1'h1)
        begin
            num_errors++;
            $display("[ERR] %0t load never returned", $time);
            stop_test();
        end
        if (z == 2'h2) w = {{16{x & w[15]}}, w[15:0]};
        if (z == 2'h1) w = {{24{x & w[7]}}, w[7:0]};
        chk(ldd, w);
        chk(ldi, d);
    endtask
    task t_ld;
        logic [31:0] a;
        logic ok;
        for (int m = 0; m < 4; m++)
            for (int z = 0; z < 4; z++)
                for (int x = 0; x < 2; x++)
                begin
                    @(posedge clk);
                    op <= OP_LD;
                    wbm <= 2'(m);
                    sz <= 2'(z);
                    sx <= x[0];
                    byp <= x[0] ^ m[0];
                    lat <= 4'(m);
                    issue();
                    ok = z != 3 && !(z == 0 && x == 1) && !(m == 3 && z == 1);
                    a = m == 2 ? s1 : m == 3 ? s1 + (s2 << (z == 0 ? 2 : 1)) : s1 + s2;
                    chk(exi, !ok);
                    chk(wbwe, ok && (m == 1 || m == 2));
                    if (ok && wbwe) chk(wbd, s1 + s2);
                    if (ok && wbwe) chk(wbi, bidx);
                    if (ok) chk(mbyp, x[0] ^ m[0]);
                    if (ok) ld_wait(a, 2'(z), x[0], dst);
                end
    endtask
    task t_compact;
        logic [1:0] zt [6] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h2, 2'h0};
        logic [31:0] a, u, g;
        int sh;
        u = {21'h0, imm};
        g = {{21{imm[10]}}, imm};
        for (int k = 0; k < 6; k++)
        begin
            @(posedge clk);
            op <= op_t'(k + 2);
            sz <= zt[k];
            sx <= 1'h1;
            byp <= 1'h1;
            wbm <= 2'h1;
            issue();
            sh = zt[k] == 2'h0 ? 2 : zt[k] == 2'h2 ? 1 : 0;
            a = k == 0 ? s1 + s2 : k == 3 ? sp + (u << sh) : s1 + (u << sh);
            if (k == 4) a = gp + (g << sh);
            if (k == 5) a = (pc & ~32'h3) + (u << 2);
            chk(wbwe, 1'h0);
            chk(mbyp, 1'h0);
            ld_wait(a, zt[k], k == 2, k == 4 ? R0_REG : dst);
        end
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'h1;
        t_cond();
        t_reset();
        t_slot();
        t_hold();
        t_ld();
        t_compact();
        stop_test();
    end
endmodule
bind jl_ld_exec jl_ld_exec_checker chk_i (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .CE(CE),
    .ISSUE_VALID(ISSUE_VALID), .ISSUE_OP(ISSUE_OP), .MEM_RVALID(MEM_RVALID), .BUSY(BUSY),
    .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .SLOT_KILL(SLOT_KILL), .WB_WE(WB_WE),
    .WB_IDX(WB_IDX), .MEM_REQ(MEM_REQ), .MEM_SIZE(MEM_SIZE), .LD_WE(LD_WE),
    .EXC_SEQ(EXC_SEQ), .EXC_INSTR(EXC_INSTR), .FLAG_WE(FLAG_WE));
